// ### inc/fcd_pkg.sv
package fcd_pkg;
	// command codes and unlock addresses
	localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_AUTOSEL = 8'h90;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [11:0] WORD_ADDR1 = 12'h555;
	localparam logic [11:0] WORD_ADDR2 = 12'h2aa;
	localparam logic [11:0] BYTE_ADDR1 = 12'haaa;
	localparam logic [11:0] BYTE_ADDR2 = 12'h555;
	// autoselect read offsets, word mode and byte mode
	localparam logic [11:0] WORD_ID_ADDR = 12'h001;
	localparam logic [11:0] BYTE_ID_ADDR = 12'h002;
	localparam logic [11:0] WORD_PROT_ADDR = 12'h002;
	localparam logic [11:0] BYTE_PROT_ADDR = 12'h004;
	localparam logic [11:0] MFR_ADDR = 12'h000;
	// sector field position
	localparam int SECTOR_LSB = 12;
	localparam int SECTOR_W = 7;
	// strobe timing in mclk cycles
	localparam int SETUP_CYC = 2;
	localparam int PULSE_CYC = 2;
	localparam int HOLD_CYC = 2;
	localparam int READ_CYC = 3;

	typedef enum logic [3:0] {
		OP_RESET, OP_AUTOSEL_ID, OP_AUTOSEL_MFR, OP_PROT_VERIFY,
		OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SUSPEND,
		OP_RESUME, OP_READ
	} fcd_op_t;

	// one host request
	typedef struct packed {
		fcd_op_t op;
		logic [19:0] addr;
		logic [15:0] data;
	} fcd_req_t;

	// one bus cycle to the flash
	typedef struct packed {
		logic wr;
		logic [19:0] addr;
		logic [15:0] data;
	} fcd_cyc_t;

	// pin bundle towards the flash
	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic [19:0] addr;
		logic [15:0] dq_out;
		logic dq_oe;
	} fcd_pins_t;
endpackage : fcd_pkg

// ### verilog/fcd_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
// runs one write or read strobe cycle on the flash pins
module fcd_bus_cycle (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic start,
	input wire fcd_pkg::fcd_cyc_t cyc,
	input wire logic [15:0] dq_in,
	output var fcd_pkg::fcd_pins_t pins,
	output logic done,
	output logic [15:0] rdata
);
	typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_PULSE, BC_HOLD} fcd_bc_t;
	fcd_bc_t st_q;
	logic [3:0] cnt_q;
	fcd_pkg::fcd_cyc_t cyc_q;

	// phase sequencer; oe stays high during writes so the strobe qualifies
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q <= BC_IDLE;
			cnt_q <= 4'h0;
			cyc_q <= '0;
		end
		else
		begin
			unique case (st_q)
				BC_IDLE:
				if (start)
				begin
					cyc_q <= cyc;
					st_q <= BC_SETUP;
					cnt_q <= 4'(fcd_pkg::SETUP_CYC - 1);
				end
				BC_SETUP:
				if (cnt_q == 4'h0)
				begin
					st_q <= BC_PULSE;
					cnt_q <= cyc_q.wr ? 4'(fcd_pkg::PULSE_CYC - 1) : 4'(fcd_pkg::READ_CYC - 1);
				end
				else
					cnt_q <= cnt_q - 4'h1;
				BC_PULSE:
				if (cnt_q == 4'h0)
				begin
					st_q <= BC_HOLD;
					cnt_q <= 4'(fcd_pkg::HOLD_CYC - 1);
				end
				else
					cnt_q <= cnt_q - 4'h1;
				BC_HOLD:
				if (cnt_q == 4'h0)
					st_q <= BC_IDLE;
				else
					cnt_q <= cnt_q - 4'h1;
			endcase
		end
	end

	// pins registered; address set before we falls, data held past we rising
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			pins.ce_n <= 1'b1;
			pins.we_n <= 1'b1;
			pins.oe_n <= 1'b1;
			pins.addr <= '0;
			pins.dq_out <= '0;
			pins.dq_oe <= 1'b0;
		end
		else
		begin
			pins.ce_n <= !(st_q != BC_IDLE);
			pins.we_n <= !(st_q == BC_PULSE && cyc_q.wr);
			pins.oe_n <= !(st_q == BC_PULSE && !cyc_q.wr);
			pins.addr <= cyc_q.addr;
			pins.dq_out <= cyc_q.data;
			pins.dq_oe <= (st_q != BC_IDLE) && cyc_q.wr;
		end
	end

	// completion pulse and read capture at end of oe pulse
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			done <= 1'b0;
			rdata <= 16'h0000;
		end
		else
		begin
			done <= (st_q == BC_HOLD) && (cnt_q == 4'h0);
			if (st_q == BC_PULSE && cnt_q == 4'h0 && !cyc_q.wr)
				rdata <= dq_in;
		end
	end
endmodule : fcd_bus_cycle
`default_nettype wire

// ### verilog/fcd_host.sv
// Contract
// - host writes with ce and we low, oe held high
// - program, erase and autoselect start with aa, 55 unlock writes at mode addresses; reset, suspend, resume are one write
// - program: two unlocks, a0, then location and value
// - chip erase: unlocks, 80, unlocks, 10
// - sector erase: five chip erase writes then 30 at sector
// - host reports bit 5 of each read on timeout_seen
// - width select low: byte addresses, high: word addresses
`timescale 1ns/1ps
`default_nettype none
module fcd_host (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic req_valid,
	input wire fcd_pkg::fcd_req_t req,
	input wire logic word_mode,
	input wire logic [15:0] dq_in,
	output logic req_ready,
	output logic resp_valid,
	output logic [15:0] resp_data,
	output logic timeout_seen,
	output logic ce_n,
	output logic we_n,
	output logic oe_n,
	output logic [19:0] addr,
	output logic [15:0] dq_out,
	output logic dq_oe,
	output logic byte_n
);
	typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} fcd_hst_t;
	fcd_hst_t st_q;
	fcd_pkg::fcd_req_t req_q;
	logic [2:0] step_q;
	logic [2:0] last_q;
	logic start_q;
	fcd_pkg::fcd_cyc_t cyc_q;
	fcd_pkg::fcd_pins_t pins;
	logic bc_done;
	logic [15:0] bc_rdata;

	// unlock address for a given position; low bits only matter to the device
	function automatic logic [19:0] unlock_addr(input logic wm, input logic second);
		logic [11:0] a;
		a = wm ? (second ? fcd_pkg::WORD_ADDR2 : fcd_pkg::WORD_ADDR1)
			: (second ? fcd_pkg::BYTE_ADDR2 : fcd_pkg::BYTE_ADDR1);
		return {8'h00, a};
	endfunction : unlock_addr

	// number of bus cycles per operation, minus one
	function automatic logic [2:0] op_last(input fcd_pkg::fcd_op_t op);
		unique case (op)
			fcd_pkg::OP_RESET, fcd_pkg::OP_SUSPEND, fcd_pkg::OP_RESUME,
			fcd_pkg::OP_READ: return 3'h0;
			fcd_pkg::OP_PROGRAM, fcd_pkg::OP_AUTOSEL_ID, fcd_pkg::OP_AUTOSEL_MFR,
			fcd_pkg::OP_PROT_VERIFY: return 3'h3;
			default: return 3'h5;
		endcase
	endfunction : op_last

	// builds the cycle for position s of the sequence
	function automatic fcd_pkg::fcd_cyc_t seq_cyc(input fcd_pkg::fcd_req_t r,
		input logic wm, input logic [2:0] s);
		fcd_pkg::fcd_cyc_t c;
		logic [19:0] sec;
		logic second;
		c.wr = 1'b1;
		// erases repeat the unlock pair at steps 3 and 4, so parity alone is wrong
		second = (s == 3'h1) || (s == 3'h4);
		c.addr = unlock_addr(wm, second);
		c.data = {8'h00, second ? fcd_pkg::CMD_UNLOCK2 : fcd_pkg::CMD_UNLOCK1};
		sec = {r.addr[19:fcd_pkg::SECTOR_LSB], 12'h000};
		unique case (r.op)
			fcd_pkg::OP_RESET: c.data = {8'h00, fcd_pkg::CMD_RESET};
			fcd_pkg::OP_SUSPEND: c.data = {8'h00, fcd_pkg::CMD_SUSPEND};
			fcd_pkg::OP_RESUME: c.data = {8'h00, fcd_pkg::CMD_RESUME};
			fcd_pkg::OP_READ:
			begin
				c.wr = 1'b0;
				c.addr = r.addr;
			end
			default:
			begin
				if (s == 3'h2)
				begin
					c.addr = unlock_addr(wm, 1'b0);
					unique case (r.op)
						fcd_pkg::OP_PROGRAM: c.data = {8'h00, fcd_pkg::CMD_PROGRAM};
						fcd_pkg::OP_CHIP_ERASE, fcd_pkg::OP_SECTOR_ERASE:
							c.data = {8'h00, fcd_pkg::CMD_ERASE_SETUP};
						default: c.data = {8'h00, fcd_pkg::CMD_AUTOSEL};
					endcase
				end
				else if (s == 3'h3)
				begin
					unique case (r.op)
						fcd_pkg::OP_PROGRAM:
						begin
							c.addr = r.addr;
							c.data = r.data;
						end
						fcd_pkg::OP_AUTOSEL_ID:
						begin
							c.wr = 1'b0;
							c.addr = {8'h00, wm ? fcd_pkg::WORD_ID_ADDR : fcd_pkg::BYTE_ID_ADDR};
						end
						fcd_pkg::OP_AUTOSEL_MFR:
						begin
							c.wr = 1'b0;
							c.addr = {8'h00, fcd_pkg::MFR_ADDR};
						end
						fcd_pkg::OP_PROT_VERIFY:
						begin
							c.wr = 1'b0;
							c.addr = sec | {8'h00, wm ? fcd_pkg::WORD_PROT_ADDR
								: fcd_pkg::BYTE_PROT_ADDR};
						end
						default: c.addr = unlock_addr(wm, 1'b0);
					endcase
				end
				else if (s == 3'h5)
				begin
					if (r.op == fcd_pkg::OP_SECTOR_ERASE)
					begin
						c.addr = sec;
						c.data = {8'h00, fcd_pkg::CMD_SECTOR_ERASE};
					end
					else
					begin
						c.addr = unlock_addr(wm, 1'b0);
						c.data = {8'h00, fcd_pkg::CMD_CHIP_ERASE};
					end
				end
			end
		endcase
		return c;
	endfunction : seq_cyc

	fcd_bus_cycle u_cycle (
		.mclk(mclk),
		.resetn(resetn),
		.start(start_q),
		.cyc(cyc_q),
		.dq_in(dq_in),
		.pins(pins),
		.done(bc_done),
		.rdata(bc_rdata)
	);

	// request sequencer: whole sequences issued back to back, never interleaved
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q <= H_IDLE;
			req_q <= '0;
			step_q <= 3'h0;
			last_q <= 3'h0;
			start_q <= 1'b0;
			cyc_q <= '0;
			req_ready <= 1'b0;
		end
		else
		begin
			start_q <= 1'b0;
			unique case (st_q)
				H_IDLE:
				begin
					req_ready <= 1'b1;
					if (req_valid && req_ready)
					begin
						req_ready <= 1'b0;
						req_q <= req;
						step_q <= 3'h0;
						last_q <= op_last(req.op);
						st_q <= H_ISSUE;
					end
				end
				H_ISSUE:
				begin
					cyc_q <= seq_cyc(req_q, word_mode, step_q);
					start_q <= 1'b1;
					st_q <= H_WAIT;
				end
				H_WAIT:
				if (bc_done)
				begin
					if (step_q == last_q)
						st_q <= H_IDLE;
					else
					begin
						step_q <= step_q + 3'h1;
						st_q <= H_ISSUE;
					end
				end
				default: st_q <= H_IDLE;
			endcase
		end
	end

	// answer and timeout bit watch on reads
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			resp_valid <= 1'b0;
			resp_data <= 16'h0000;
			timeout_seen <= 1'b0;
		end
		else
		begin
			resp_valid <= (st_q == H_WAIT) && bc_done && (step_q == last_q);
			if ((st_q == H_WAIT) && bc_done && (step_q == last_q))
				resp_data <= bc_rdata;
			if ((st_q == H_WAIT) && bc_done && !cyc_q.wr)
				timeout_seen <= bc_rdata[5];
		end
	end

	// pins straight from the cycle engine flops
	always_comb
	begin
		ce_n = pins.ce_n;
		we_n = pins.we_n;
		oe_n = pins.oe_n;
		addr = pins.addr;
		dq_out = pins.dq_out;
		dq_oe = pins.dq_oe;
	end

	// width select pin registered from the mode input
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			byte_n <= 1'b0;
		else
			byte_n <= word_mode;
	end
endmodule : fcd_host
`default_nettype wire

// ### verif/fcd_host_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fcd_host_monitor (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic resp_valid,
	input wire logic word_mode,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [19:0] addr,
	input wire logic [15:0] dq_out,
	input wire logic dq_oe,
	input wire logic byte_n
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	// write strobe only inside chip select with outputs off
	AST_WR_QUAL: assert property (!we_n |-> !ce_n && oe_n && dq_oe)
		else $error("write strobe not qualified");
	// address and data steady through the strobe
	AST_WR_HOLD: assert property (!we_n && $past(!we_n) |-> $stable(addr) && $stable(dq_out))
		else $error("write bus moved under strobe");
	// never drive dq while the flash may drive it
	AST_NO_CLASH: assert property (!oe_n |-> !dq_oe && we_n)
		else $error("read overlaps drive");
	AST_WIDTH: assert property (req_valid && req_ready |=> byte_n == $past(word_mode))
		else $error("width pin wrong");
	AST_WE_PULSE: assert property ($fell(we_n) |-> !we_n ##1 !we_n ##1 we_n)
		else $error("write pulse length");
	AST_CE_LEN: assert property ($fell(ce_n) |-> !ce_n [*5] ##[1:3] ce_n)
		else $error("chip select length");
	AST_RESP: assert property (resp_valid |=> !resp_valid)
		else $error("response not a pulse");
	AST_TAKE: assert property (req_valid && req_ready |=> !req_ready)
		else $error("ready after take");
endmodule : fcd_host_monitor
bind fcd_host fcd_host_monitor u_mon (.mclk, .resetn, .req_valid, .req_ready, .resp_valid,
	.word_mode, .ce_n, .we_n, .oe_n, .addr, .dq_out, .dq_oe, .byte_n);
`default_nettype wire

// ### verif/fcd_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fcd_flash_model #(
	// identity codes arbitrary; status word is the model's own busy marker
	parameter logic [15:0] MFR_CODE = 16'h00c3,
	parameter logic [15:0] DEV_CODE = 16'h4d21,
	parameter logic [15:0] STAT_CODE = 16'h0004,
	parameter int ERASE_NS = 2000
) (
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [19:0] addr,
	input wire logic [15:0] dq_out,
	input wire logic byte_n,
	output logic [15:0] dq_in,
	output logic [7:0] last_cmd,
	output logic [19:0] last_a,
	output logic [1:0] mode
);
	logic locked = 1'b1;
	logic [19:0] a_lat;
	logic [19:0] pl = '1;
	logic [15:0] pv = '0;
	logic [15:0] rd;
	logic [11:0] u1, u2;
	logic [1:0] idx;
	logic [7:0] sec_q = '0;
	time busy_until = 0;
	int st = 0;
	// power-up lockout, writes ignored until supply settles
	initial
	begin
		mode = 2'd0;
		last_cmd = 8'h00;
		last_a = '0;
		#100 locked = 1'b0;
	end
	assign u1 = byte_n ? 12'h555 : 12'haaa;
	assign u2 = byte_n ? 12'h2aa : 12'h555;
	assign idx = byte_n ? addr[1:0] : addr[2:1];
	// address on the later falling strobe
	always @(negedge we_n or negedge ce_n)
		if (!we_n && !ce_n) a_lat = addr;
	// data on the earlier rising strobe; oe low makes it a read
	always @(posedge we_n or posedge ce_n)
		if (!locked && oe_n && !(we_n && ce_n)) cmd(a_lat, dq_out[7:0]);
	task automatic cmd(input logic [19:0] a, input logic [7:0] d);
		logic h1, h2;
		h1 = a[11:0] == u1;
		h2 = a[11:0] == u2;
		if ($time < busy_until)
			st = 0;
		else if (mode == 2'd3)
		begin
			// erase running: reset and the rest are dropped
			if (d == 8'hb0)
				mode = 2'd2;
		end
		else if (st == 3)
		begin
			pl = a;
			pv = dq_out;
			last_a = a;
			last_cmd = 8'ha0;
			st = 0;
		end
		else if (d == 8'hf0)
		begin
			mode = mode == 2'd1 ? 2'd0 : mode;
			last_cmd = d;
			st = 0;
		end
		else if (mode == 2'd1)
			st = 0;
		else if (st == 0 && mode == 2'd2 && d == 8'h30)
			mode = 2'd3;
		else if ((st == 0 || st == 4) && h1 && d == 8'haa ||
			(st == 1 || st == 5) && h2 && d == 8'h55)
			st = st + 1;
		else if (st == 2 && h1 && (d == 8'h90 || d == 8'ha0 || d == 8'h80))
		begin
			st = d == 8'h90 ? 0 : d == 8'ha0 ? 3 : 4;
			mode = d == 8'h90 ? 2'd1 : mode;
		end
		else if (st == 6 && (h1 && d == 8'h10 || d == 8'h30))
		begin
			last_cmd = d;
			last_a = a;
			st = 0;
			if (d == 8'h10)
				busy_until = $time + ERASE_NS;
			else
			begin
				mode = 2'd3;
				sec_q = a[19:12];
			end
		end
		else
		begin
			last_cmd = 8'hee;
			st = 0;
		end
	endtask : cmd
	// codes in autoselect, status in the erase sector, array otherwise
	always_comb
		if (mode == 2'd1)
			rd = idx == 0 ? MFR_CODE : idx == 1 ? DEV_CODE : 16'h0001;
		else if (mode[1] && addr[19:12] == sec_q)
			rd = STAT_CODE;
		else
			rd = addr == pl ? pv : addr[15:0] ^ 16'h5a5a;
	// released bus shows the inverse, never a stale match
	assign dq_in = (!ce_n && !oe_n) ? rd : ~rd;
endmodule : fcd_flash_model
`default_nettype wire

// ### verif/flash_command_sequence_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module flash_command_sequence_decoder_test;
	// identity codes are arbitrary
	localparam logic [15:0] MFR = 16'h00c3;
	localparam logic [15:0] DEV = 16'h4d21;
	localparam logic [15:0] STAT = 16'h0004;
	logic mclk = 0;
	logic resetn = 0;
	logic req_valid = 0;
	logic word_mode = 1;
	fcd_pkg::fcd_req_t req = '0;
	logic req_ready, resp_valid, timeout_seen, ce_n, we_n, oe_n, dq_oe, byte_n;
	logic [15:0] resp_data, dq_in, dq_out;
	logic [19:0] addr, last_a;
	logic [7:0] last_cmd;
	logic [1:0] mode;
	int n_fail = 0;
	int n_tests = 0;
	fcd_host u_dut (.mclk, .resetn, .req_valid, .req, .word_mode, .dq_in, .req_ready,
		.resp_valid, .resp_data, .timeout_seen, .ce_n, .we_n, .oe_n, .addr, .dq_out,
		.dq_oe, .byte_n);
	fcd_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .STAT_CODE(STAT)) u_flash (.ce_n,
		.we_n, .oe_n,
		.addr, .dq_out, .byte_n, .dq_in, .last_cmd, .last_a, .mode);
	initial forever #20 mclk = ~mclk;
	task automatic complete_run;
		if (n_fail == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one request, released after the taking edge
	task automatic do_req(input fcd_pkg::fcd_op_t op, input logic [19:0] a,
		input logic [15:0] d);
		int i;
		@(negedge mclk);
		req = '{op, a, d};
		req_valid = 1;
		for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge mclk);
		if (i >= 20)
		begin
			n_fail++;
			complete_run;
		end
		@(negedge mclk);
		req_valid = 0;
		for (i = i; i < 200 && resp_valid !== 1'b1; i++) @(negedge mclk);
		if (i >= 200)
		begin
			n_fail++;
			complete_run;
		end
	endtask : do_req
	task automatic t_read;
		do_req(fcd_pkg::OP_READ, 20'h00020, 16'h0000);
		chk("array", 16'h5a7a, resp_data);
		chk("timeout", 1'b1, timeout_seen);
		do_req(fcd_pkg::OP_RESET, 20'h00000, 16'h0000);
		chk("reset", 8'hf0, last_cmd);
	endtask : t_read
	// both widths, unlock addresses follow the pin
	task automatic t_prog(input logic wm, input logic [19:0] a, input logic [15:0] d);
		word_mode = wm;
		do_req(fcd_pkg::OP_PROGRAM, a, d);
		chk("prog cmd", 8'ha0, last_cmd);
		chk("prog loc", a, last_a);
		do_req(fcd_pkg::OP_READ, a, 16'h0000);
		chk("readback", d, resp_data);
	endtask : t_prog
	task automatic t_auto;
		do_req(fcd_pkg::OP_AUTOSEL_ID, 20'h00000, 16'h0000);
		chk("dev id", DEV, resp_data);
		do_req(fcd_pkg::OP_READ, 20'h00000, 16'h0000);
		chk("mfr", MFR, resp_data);
		do_req(fcd_pkg::OP_PROT_VERIFY, 20'h3f000, 16'h0000);
		chk("protect", 16'h0001, resp_data);
		do_req(fcd_pkg::OP_RESET, 20'h00000, 16'h0000);
		chk("mode", 2'd0, mode);
	endtask : t_auto
	task automatic t_erase;
		do_req(fcd_pkg::OP_CHIP_ERASE, 20'h00000, 16'h0000);
		chk("chip erase", 8'h10, last_cmd);
		// a reset while the chip erase runs must be dropped
		do_req(fcd_pkg::OP_RESET, 20'h00000, 16'h0000);
		chk("busy reset", 8'h10, last_cmd);
		repeat (60) @(negedge mclk);
		do_req(fcd_pkg::OP_SECTOR_ERASE, 20'h45abc, 16'h0000);
		chk("sector cmd", 8'h30, last_cmd);
		chk("sector", 20'h45000, last_a);
		do_req(fcd_pkg::OP_RESET, 20'h00000, 16'h0000);
		chk("erasing", 2'd3, mode);
		do_req(fcd_pkg::OP_SUSPEND, 20'h12345, 16'h0000);
		chk("suspend", 2'd2, mode);
		do_req(fcd_pkg::OP_READ, 20'h45100, 16'h0000);
		chk("in sector", STAT, resp_data);
		do_req(fcd_pkg::OP_READ, 20'h00020, 16'h0000);
		chk("out sector", 16'h5a7a, resp_data);
		do_req(fcd_pkg::OP_RESUME, 20'h54321, 16'h0000);
		chk("resume", 2'd3, mode);
	endtask : t_erase
	initial
	begin
		repeat (16) @(negedge mclk);
		resetn = 1;
		t_read;
		t_prog(1'b0, 20'h00246, 16'h0037);
		t_prog(1'b1, 20'h01234, 16'hbeef);
		t_auto;
		t_erase;
		complete_run;
	end
endmodule : flash_command_sequence_decoder_test
`default_nettype wire
